// ---- ues_core.sv ----
// USB event flags and endpoint 0 control behind an AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "ues_regs.svh"
module ues_core (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic      [31:0]         hrdata,
	output logic                     hresp,
	input  wire ues_pkg::ues_sie_ev_s sie_ev,
	output ues_pkg::ues_reply_s      ep0_reply,
	output ues_pkg::ues_reply_s      ep12_reply,
	output logic                     ep0_tx_pid,
	output logic      [3:0]          ep0_tx_byte_count,
	output logic                     usb_suspend,
	output logic                     chip_reset_req,
	output logic                     usb_irq
);

	ues_pkg::ues_state_s s;
	ues_pkg::ues_state_s next_s;

	logic       addr_ok;
	logic [9:0] addr_index;
	logic       wr_status;
	logic [7:0] wdata;
	logic [7:0] flag_set;
	logic [7:0] flag_d;
	logic [7:0] flag_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Only whole-word transfers, NONSEQ or SEQ, are taken; others finish OKAY
	assign addr_ok    = hsel && hready && htrans[1] && (hsize == 3'h2);
	assign addr_index = haddr[11:2];
	assign wdata      = hwdata[7:0];
	assign wr_status  = s.wr_pend && (s.wr_index == `UES_IDX_STATUS);

	function automatic ues_pkg::ues_reply_e ep_decide(
		input logic stall,
		input logic enable,
		input logic done
	);
		ues_pkg::ues_reply_e r;
		r = ues_pkg::UES_REPLY_NAK;
		if (stall) begin
			r = ues_pkg::UES_REPLY_STALL;
		end else if (enable && !done) begin
			r = ues_pkg::UES_REPLY_DATA;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Event flags

	always_comb begin
		flag_set = 8'h00;
		flag_set[`UES_ST_BUS_RESET]    = sie_ev.bus_reset;
		flag_set[`UES_ST_EP0_TX_DONE]  = sie_ev.ep0_tx_acked;
		flag_set[`UES_ST_EP0_RX_DONE]  = sie_ev.ep0_rx_acked;
		flag_set[`UES_ST_EP12_TX_DONE] = sie_ev.ep12_tx_acked;
		flag_set[`UES_ST_END_PACKET]   = sie_ev.end_packet;
		flag_set[`UES_ST_RESUME]       = sie_ev.activity && flag_q[`UES_ST_SUSPEND];
	end

	ues_flag_bank #(
		.W   (8),
		.RST (`UES_STATUS_RST)
	) u_flags (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set     (flag_set),
		.wr_en   (wr_status),
		.wr_data (wdata),
		.wr_mask (`UES_ST_WRITABLE),
		.d       (flag_d),
		.q       (flag_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s            = s;
		next_s.hreadyout  = 1'b1;
		next_s.hresp      = 1'b0;
		next_s.chip_reset = 1'b0;
		next_s.ep0_reply  = '{valid: 1'b0, code: ues_pkg::UES_REPLY_NAK};
		next_s.ep12_reply = '{valid: 1'b0, code: ues_pkg::UES_REPLY_NAK};

		// Data phase of a write lands here
		if (s.wr_pend) begin
			unique case (s.wr_index)
				`UES_IDX_ENABLE: begin
					next_s.enable = wdata;
				end
				`UES_IDX_CTRL0: begin
					next_s.ctrl0 = wdata;
				end
				`UES_IDX_CTRL12: begin
					next_s.ep12_tx_enable = wdata[`UES_C12_TX_EN];
				end
				default: begin
					next_s.ctrl0 = next_s.ctrl0;
				end
			endcase
		end

		if (sie_ev.setup_token && !(s.wr_pend && s.wr_index == `UES_IDX_CTRL0)) begin
			next_s.ctrl0[`UES_C0_STALL] = 1'b0;
		end

		next_s.chip_reset = sie_ev.bus_reset && s.enable[`UES_EN_PROPAGATE];

		// stall wins for in and out
		if (sie_ev.ep0_in_token) begin
			next_s.ep0_reply.valid = 1'b1;
			next_s.ep0_reply.code  = ep_decide(s.ctrl0[`UES_C0_STALL],
				s.ctrl0[`UES_C0_TX_EN], flag_q[`UES_ST_EP0_TX_DONE]);
		end else if (sie_ev.ep0_out_token) begin
			next_s.ep0_reply.valid = 1'b1;
			next_s.ep0_reply.code  = ep_decide(s.ctrl0[`UES_C0_STALL],
				s.ctrl0[`UES_C0_RX_EN], flag_q[`UES_ST_EP0_RX_DONE]);
		end

		if (sie_ev.ep12_in_token) begin
			next_s.ep12_reply.valid = 1'b1;
			next_s.ep12_reply.code  = ep_decide(1'b0, s.ep12_tx_enable,
				flag_q[`UES_ST_EP12_TX_DONE]);
		end

		next_s.irq = |(flag_d & next_s.enable & `UES_ST_IRQ_MASK);

		// Address phase; reads see any write landing this cycle
		next_s.wr_pend = addr_ok && hwrite;
		if (addr_ok && hwrite) begin
			next_s.wr_index = addr_index;
		end
		if (addr_ok && !hwrite) begin
			unique case (addr_index)
				`UES_IDX_STATUS: begin
					next_s.hrdata = {24'h000000, flag_d};
				end
				`UES_IDX_ENABLE: begin
					next_s.hrdata = {24'h000000, next_s.enable};
				end
				`UES_IDX_CTRL0: begin
					next_s.hrdata = {24'h000000, next_s.ctrl0};
				end
				`UES_IDX_CTRL12: begin
					next_s.hrdata = {31'h00000000, next_s.ep12_tx_enable};
				end
				default: begin
					next_s.hrdata = 32'h00000000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s.enable         <= `UES_ENABLE_RST;
			s.ctrl0          <= `UES_CTRL0_RST;
			s.ep12_tx_enable <= `UES_CTRL12_RST;
			s.wr_pend        <= 1'b0;
			s.wr_index       <= 10'h000;
			s.hrdata         <= 32'h00000000;
			s.hreadyout      <= 1'b1;
			s.hresp          <= 1'b0;
			s.irq            <= 1'b0;
			s.chip_reset     <= 1'b0;
			s.ep0_reply      <= '{valid: 1'b0, code: ues_pkg::UES_REPLY_NAK};
			s.ep12_reply     <= '{valid: 1'b0, code: ues_pkg::UES_REPLY_NAK};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign hreadyout         = s.hreadyout;
	assign hrdata            = s.hrdata;
	assign hresp             = s.hresp;
	assign ep0_reply         = s.ep0_reply;
	assign ep12_reply        = s.ep12_reply;
	assign ep0_tx_pid        = s.ctrl0[`UES_C0_PID];
	assign ep0_tx_byte_count = s.ctrl0[`UES_C0_COUNT_HI:0];
	assign usb_suspend       = flag_q[`UES_ST_SUSPEND];
	assign chip_reset_req    = s.chip_reset;
	assign usb_irq           = s.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	ep0_stall_reply_a: assert property (
		sie_ev.ep0_in_token && s.ctrl0[`UES_C0_STALL]
		|=> ep0_reply.valid && ep0_reply.code == ues_pkg::UES_REPLY_STALL)
		else $error("stall bit set but no stall reply");

	ep0_in_nak_a: assert property (
		sie_ev.ep0_in_token && !s.ctrl0[`UES_C0_STALL]
		&& flag_q[`UES_ST_EP0_TX_DONE]
		|=> ep0_reply.code == ues_pkg::UES_REPLY_NAK)
		else $error("in token not nakked while tx done");

	ep0_in_data_a: assert property (
		sie_ev.ep0_in_token && !s.ctrl0[`UES_C0_STALL]
		&& s.ctrl0[`UES_C0_TX_EN] && !flag_q[`UES_ST_EP0_TX_DONE]
		|=> ep0_reply.valid && ep0_reply.code == ues_pkg::UES_REPLY_DATA)
		else $error("ready in token did not get data");

	ep0_out_gate_a: assert property (
		sie_ev.ep0_out_token && !sie_ev.ep0_in_token
		&& !s.ctrl0[`UES_C0_STALL]
		|=> ep0_reply.code == (($past(s.ctrl0[`UES_C0_RX_EN])
			&& !$past(flag_q[`UES_ST_EP0_RX_DONE]))
			? ues_pkg::UES_REPLY_DATA : ues_pkg::UES_REPLY_NAK))
		else $error("out token reply does not match enable and done");

	ep0_tx_done_a: assert property (
		sie_ev.ep0_tx_acked |=> flag_q[`UES_ST_EP0_TX_DONE])
		else $error("tx done flag not set after ack");

	ep0_rx_done_a: assert property (
		sie_ev.ep0_rx_acked |=> flag_q[`UES_ST_EP0_RX_DONE])
		else $error("rx done flag not set after ack");

	ep12_nak_a: assert property (
		sie_ev.ep12_in_token && flag_q[`UES_ST_EP12_TX_DONE]
		|=> ep12_reply.valid && ep12_reply.code == ues_pkg::UES_REPLY_NAK)
		else $error("shared endpoint not nakked while done");

	ep12_done_a: assert property (
		sie_ev.ep12_tx_acked |=> flag_q[`UES_ST_EP12_TX_DONE])
		else $error("shared tx done not set after ack");

	eop_flag_a: assert property (
		sie_ev.end_packet |=> flag_q[`UES_ST_END_PACKET])
		else $error("end of packet flag not set");

	resume_flag_a: assert property (
		sie_ev.activity && usb_suspend |=> flag_q[`UES_ST_RESUME])
		else $error("resume flag not set on activity in suspend");

	bus_reset_flag_a: assert property (
		sie_ev.bus_reset |=> flag_q[`UES_ST_BUS_RESET] [*2])
		else $error("bus reset flag not set or not held");

	chip_reset_a: assert property (
		sie_ev.bus_reset |=> chip_reset_req == $past(s.enable[`UES_EN_PROPAGATE]))
		else $error("chip reset does not follow propagate enable");

	stall_clear_a: assert property (
		sie_ev.setup_token && !s.wr_pend |=> !s.ctrl0[`UES_C0_STALL])
		else $error("setup token did not clear stall");

	irq_pair_a: assert property (
		usb_irq == |(flag_q & s.enable & `UES_ST_IRQ_MASK))
		else $error("interrupt request disagrees with flags and enables");

	pid_steady_a: assert property (
		!s.wr_pend |=> $stable(ep0_tx_pid))
		else $error("sequence bit changed without a write");

	ep0_out_stall_a: assert property (
		sie_ev.ep0_out_token && !sie_ev.ep0_in_token && s.ctrl0[`UES_C0_STALL]
		|=> ep0_reply.valid && ep0_reply.code == ues_pkg::UES_REPLY_STALL)
		else $error("stall bit set but out token not stalled");

	ep12_data_a: assert property (
		sie_ev.ep12_in_token && s.ep12_tx_enable && !flag_q[`UES_ST_EP12_TX_DONE]
		|=> ep12_reply.valid && ep12_reply.code == ues_pkg::UES_REPLY_DATA)
		else $error("ready shared endpoint did not get data");

	count_steady_a: assert property (
		!s.wr_pend |=> $stable(ep0_tx_byte_count))
		else $error("byte count changed without a write");

	chip_reset_pulse_a: assert property (
		!sie_ev.bus_reset |=> !chip_reset_req)
		else $error("chip reset raised without a bus reset");

	ep0_reply_idle_a: assert property (
		!sie_ev.ep0_in_token && !sie_ev.ep0_out_token
		|=> !ep0_reply.valid)
		else $error("endpoint 0 reply without a token");

	reset_flag_ro_a: assert property (
		!sie_ev.bus_reset
		|=> flag_q[`UES_ST_BUS_RESET] == $past(flag_q[`UES_ST_BUS_RESET]))
		else $error("bus reset flag changed without a bus reset");

	suspend_hold_a: assert property (
		!wr_status |=> $stable(usb_suspend))
		else $error("suspend flag changed without a write");

	resume_hold_a: assert property (
		!flag_q[`UES_ST_RESUME] && !wr_status && !(sie_ev.activity && usb_suspend)
		|=> !flag_q[`UES_ST_RESUME])
		else $error("resume flag set without activity in suspend");

	eop_hold_a: assert property (
		!flag_q[`UES_ST_END_PACKET] && !wr_status && !sie_ev.end_packet
		|=> !flag_q[`UES_ST_END_PACKET])
		else $error("end of packet flag set without an event");

endmodule
`default_nettype wire

// ---- ues_regs.svh ----
// Register indices, field positions and reset values of the USB event block
`ifndef UES_REGS_SVH
`define UES_REGS_SVH

`define UES_IDX_STATUS      10'h0E8
`define UES_IDX_ENABLE      10'h0E9
`define UES_IDX_CTRL0       10'h0EA
`define UES_IDX_CTRL12      10'h0F0

`define UES_ST_SUSPEND      7
`define UES_ST_BUS_RESET    5
`define UES_ST_EP0_TX_DONE  4
`define UES_ST_EP0_RX_DONE  3
`define UES_ST_EP12_TX_DONE 2
`define UES_ST_END_PACKET   1
`define UES_ST_RESUME       0
`define UES_ST_WRITABLE     8'h9F
`define UES_ST_IRQ_MASK     8'hBF

`define UES_EN_PROPAGATE    6

`define UES_C0_PID          7
`define UES_C0_STALL        6
`define UES_C0_TX_EN        5
`define UES_C0_RX_EN        4
`define UES_C0_COUNT_HI     3

`define UES_C12_TX_EN       0

`define UES_STATUS_RST      8'h00
`define UES_ENABLE_RST      8'h00
`define UES_CTRL0_RST       8'h00
`define UES_CTRL12_RST      1'b0

`endif

// ---- ues_pkg.sv ----
// Types shared by the USB event and endpoint 0 control block
package ues_pkg;

	// Handshake chosen for a token, one-hot
	typedef enum logic [2:0] {
		UES_REPLY_NAK   = 3'b001,
		UES_REPLY_STALL = 3'b010,
		UES_REPLY_DATA  = 3'b100
	} ues_reply_e;

	typedef struct packed {
		logic       valid;
		ues_reply_e code;
	} ues_reply_s;

	// One-cycle event pulses from the serial engine
	typedef struct packed {
		logic bus_reset;
		logic end_packet;
		logic activity;
		logic setup_token;
		logic ep0_in_token;
		logic ep0_out_token;
		logic ep12_in_token;
		logic ep0_tx_acked;
		logic ep0_rx_acked;
		logic ep12_tx_acked;
	} ues_sie_ev_s;

	typedef struct packed {
		logic [7:0]  enable;
		logic [7:0]  ctrl0;
		logic        ep12_tx_enable;
		logic        wr_pend;
		logic [9:0]  wr_index;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
		logic        irq;
		logic        chip_reset;
		ues_reply_s  ep0_reply;
		ues_reply_s  ep12_reply;
	} ues_state_s;

endpackage

// ---- ues_flag_bank.sv ----
// Sticky event flags with software write access; a hardware set wins
`timescale 1ns/10ps
`default_nettype none
module ues_flag_bank #(
	parameter int        W     = 8,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] set,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [W-1:0] wr_mask,
	output logic      [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] base;

	always_comb begin
		base = q;
		if (wr_en) begin
			base = (q & ~wr_mask) | (wr_data & wr_mask);
		end
		// Event in the clearing cycle must not be lost
		d = base | set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// ---- ues_host_model.sv ----
// Low-speed host model that issues tokens and acknowledges data replies
`timescale 1ns/10ps
`default_nettype none
module ues_host_model (
	input  wire ues_pkg::ues_reply_s ep0_reply,
	input  wire ues_pkg::ues_reply_s ep12_reply,
	input  wire logic                hclk,
	output ues_pkg::ues_sie_ev_s     sie_ev
);
	initial sie_ev = '0;

	////////////////////////////////////////////////////////////////////////
	// One clock per event; changed right after an edge, so no race
	task automatic send(input ues_pkg::ues_sie_ev_s ev);
		@(posedge hclk);
		sie_ev <= ev;
		@(posedge hclk);
		sie_ev <= '0;
	endtask

	// Kind 0 ep0 IN, 1 ep0 OUT, 2 ep12 IN; gap delays the ACK
	task automatic xfer(input int kind, input int gap,
			output ues_pkg::ues_reply_s rep);
		ues_pkg::ues_sie_ev_s ev;
		ev = '0;
		ev.ep0_in_token = (kind == 0);
		ev.ep0_out_token = (kind == 1);
		ev.ep12_in_token = (kind == 2);
		send(ev);
		@(posedge hclk);
		rep = (kind == 2) ? ep12_reply : ep0_reply;
		ev = '0;
		if (rep.valid === 1'b1 && rep.code === ues_pkg::UES_REPLY_DATA) begin
			repeat (gap) @(posedge hclk);
			ev.ep0_tx_acked = (kind == 0);
			ev.ep0_rx_acked = (kind == 1);
			ev.ep12_tx_acked = (kind == 2);
			send(ev);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the USB event and endpoint 0 control block
`timescale 1ns/10ps
`default_nettype none
`include "ues_regs.svh"
module tb;
	localparam logic [9:0] EV_RST   = 10'h200;
	localparam logic [9:0] EV_EOP   = 10'h100;
	localparam logic [9:0] EV_ACT   = 10'h080;
	localparam logic [9:0] EV_SETUP = 10'h040;
	localparam logic [9:0] ST = `UES_IDX_STATUS;
	localparam logic [9:0] EN = `UES_IDX_ENABLE;
	localparam logic [9:0] C0 = `UES_IDX_CTRL0;
	localparam logic [9:0] C12 = `UES_IDX_CTRL12;

	logic                 hclk;
	logic                 hresetn;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [2:0]           hsize;
	logic [31:0]          hwdata;
	logic                 hready;
	logic                 hreadyout;
	logic [31:0]          hrdata;
	logic                 hresp;
	ues_pkg::ues_sie_ev_s sie_ev;
	ues_pkg::ues_reply_s  ep0_reply;
	ues_pkg::ues_reply_s  ep12_reply;
	ues_pkg::ues_reply_s  rep;
	logic                 ep0_tx_pid;
	logic [3:0]           ep0_tx_byte_count;
	logic                 usb_suspend;
	logic                 chip_reset_req;
	logic                 usb_irq;
	logic [31:0]          rd;
	int                   n_fail = 0;
	int                   check_count = 0;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	ues_core ues_core_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .sie_ev(sie_ev), .ep0_reply(ep0_reply),
		.ep12_reply(ep12_reply), .ep0_tx_pid(ep0_tx_pid),
		.ep0_tx_byte_count(ep0_tx_byte_count), .usb_suspend(usb_suspend),
		.chip_reset_req(chip_reset_req), .usb_irq(usb_irq)
	);

	ues_host_model ues_host_model_inst (
		.ep0_reply(ep0_reply), .ep12_reply(ep12_reply), .hclk(hclk),
		.sie_ev(sie_ev)
	);

	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rep(input ues_pkg::ues_reply_s got,
			input ues_pkg::ues_reply_e exp);
		check_count++;
		if (got !== {1'b1, exp}) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, {1'b1, exp});
		end
	endtask

	// Address phase held until ready, then data phase held until ready
	task automatic bus(input logic w, input logic [9:0] idx,
			input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h00000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h00000000);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, {24'h000000, exp});
	endtask

	task automatic io(input int kind, input int gap,
			input ues_pkg::ues_reply_e exp);
		ues_host_model_inst.xfer(kind, gap, rep);
		chk_rep(rep, exp);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge hclk);
		n_fail++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(ST, 8'h00);
		rchk(C0, 8'h00);
		wr(10'h0F1, 8'hFF);
		rchk(10'h0F1, 8'h00);
		$display("test reset done");
		wr(C0, 8'hA5);
		@(posedge hclk);
		chk(32'(ep0_tx_pid), 32'h1);
		chk(32'(ep0_tx_byte_count), 32'h5);
		rchk(C0, 8'hA5);
		wr(C0, 8'h70);
		io(0, 0, ues_pkg::UES_REPLY_STALL);
		io(1, 0, ues_pkg::UES_REPLY_STALL);
		ues_host_model_inst.send(EV_SETUP);
		rchk(C0, 8'h30);
		$display("test stall done");
		io(0, 0, ues_pkg::UES_REPLY_DATA);
		rchk(ST, 8'h10);
		io(0, 0, ues_pkg::UES_REPLY_NAK);
		io(1, 2, ues_pkg::UES_REPLY_DATA);
		rchk(ST, 8'h18);
		io(1, 0, ues_pkg::UES_REPLY_NAK);
		wr(ST, 8'h00);
		io(1, 0, ues_pkg::UES_REPLY_DATA);
		io(0, 3, ues_pkg::UES_REPLY_DATA);
		rchk(ST, 8'h18);
		wr(ST, 8'h00);
		wr(C0, 8'h00);
		io(0, 0, ues_pkg::UES_REPLY_NAK);
		io(1, 0, ues_pkg::UES_REPLY_NAK);
		$display("test ep0 done");
		wr(C12, 8'h01);
		rchk(C12, 8'h01);
		io(2, 1, ues_pkg::UES_REPLY_DATA);
		rchk(ST, 8'h04);
		io(2, 0, ues_pkg::UES_REPLY_NAK);
		wr(ST, 8'h00);
		io(2, 0, ues_pkg::UES_REPLY_DATA);
		wr(C12, 8'h00);
		wr(ST, 8'h00);
		$display("test ep12 done");
		wr(EN, 8'h02);
		ues_host_model_inst.send(EV_EOP);
		@(posedge hclk);
		chk(32'(usb_irq), 32'h1);
		rchk(ST, 8'h02);
		rchk(EN, 8'h02);
		// Byte-sized write must leave the register alone
		hsize <= 3'h0;
		wr(EN, 8'hFF);
		hsize <= 3'h2;
		rchk(EN, 8'h02);
		wr(ST, 8'h00);
		@(posedge hclk);
		chk(32'(usb_irq), 32'h0);
		$display("test eop done");
		ues_host_model_inst.send(EV_ACT);
		rchk(ST, 8'h00);
		wr(ST, 8'h80);
		@(posedge hclk);
		chk(32'(usb_suspend), 32'h1);
		ues_host_model_inst.send(EV_ACT);
		rchk(ST, 8'h81);
		wr(ST, 8'h00);
		rchk(ST, 8'h00);
		$display("test resume done");
		wr(EN, 8'h20);
		ues_host_model_inst.send(EV_RST);
		@(posedge hclk);
		chk(32'(chip_reset_req), 32'h0);
		chk(32'(usb_irq), 32'h1);
		wr(ST, 8'h00);
		rchk(ST, 8'h20);
		wr(EN, 8'h40);
		ues_host_model_inst.send(EV_RST);
		@(posedge hclk);
		chk(32'(chip_reset_req), 32'h1);
		chk(32'(usb_irq), 32'h0);
		@(posedge hclk);
		chk(32'(chip_reset_req), 32'h0);
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rchk(ST, 8'h00);
		rchk(EN, 8'h00);
		$display("test bus reset done");
		summarize();
	end
endmodule
`default_nettype wire
